/* hw/hcpr_top.sv */
// Summary of operation
// - Output pin level comes from command value at source 0, direct register at 1.
// - Output pin drive type 0 is push-pull, 1 is open drain.
// - Direction 1 makes output, 0 high-impedance input; source and drive only for outputs.
// - Resistor-presence bit only for inputs; 1 connects a resistor, 0 none.
// - With resistor, pull-select 0 pulls down, 1 pulls up; ignored without resistor.
// - Opcode 0x02 returns five pin configuration bytes, pin 0 first, write layout.
// - Opcode 0x03 byte bits 4..0 set output levels of pins 4..0.
// - Opcode 0x04 returns commanded levels then sensed pin status, bits 4..0.
// - Opcode 0x06 writes one rail-enable byte per pin, fixed rail bit order.
// - Rail pin enable acts only with sequence 111 and source 10, safe output excepted; pin high enables.
// - Safe output needs only source 10; on while charger present and pin high.
// - Pin enables reset to 1 where sequence 111 and source 10, else 0.
// - Opcode 0x07 returns the five rail-enable bytes as written.
// - Opcode 0x10 byte: blanking in bits 4:3, input limit select in 2:0.
// - Charger insertion returns input limit select and blanking to defaults; thermal retry timer keeps its value.
// - Opcode 0x11 returns the input limit byte in the 0x10 layout.
// - Opcode 0x12 byte carries the two-bit thermal retry timer.
`timescale 1ns/1ps
`default_nettype none

module hcpr_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic [4:0]  multipurpose_pin_i,
  output logic      [4:0]  multipurpose_pin_o,
  output logic      [4:0]  multipurpose_pin_oe_o,
  output logic      [4:0]  pin_pull_up_o,
  output logic      [4:0]  pin_pull_down_o,
  input  wire logic [23:0] rail_sequence_setting_i,
  input  wire logic [15:0] rail_enable_source_i,
  input  wire logic        charger_input_valid_i,
  output logic      [7:0]  rail_on_o,
  output logic      [2:0]  input_limit_select_o,
  output logic      [1:0]  input_limit_blanking_o,
  output logic      [1:0]  thermal_retry_timer_o
);

  ////////////////////////////////////////////////////////////////////////////
  hcpr_pkg::hcpr_state_t state;
  logic [7:0] cmd_op;
  logic [7:0] pay_out  [0:6];
  logic [7:0] resp_pay [0:4];
  logic [7:0] resp_op;
  logic [7:0] pin_en   [0:4];
  logic [4:0] dir_vec, od_vec, src_vec, res_vec, pup_vec;
  logic [4:0] pin_level;
  logic [4:0] direct_level;
  logic       boot_loaded;
  logic       chg_prev;
  logic       chg_insert;
  logic       op_wr;
  logic [7:0] gate;
  logic [4:0] next_out, next_oe;
  logic [7:0] next_rail;

  // Strict gate: pin sequence and pin-register source
  function automatic logic [7:0] rail_strict(input logic [23:0] seq, input logic [15:0] src);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < hcpr_pkg::NUM_RAILS; i++) begin
      m[i] = (seq[3*i +: 3] == hcpr_pkg::SEQ_PIN_CTRL) && (src[2*i +: 2] == hcpr_pkg::SRC_PIN_REGS);
    end
    return m;
  endfunction : rail_strict

  function automatic logic [7:0] pin_cfg_byte(input logic [2:0] p, input logic [4:0] s, input logic [4:0] o,
                                              input logic [4:0] d, input logic [4:0] r, input logic [4:0] u);
    return {3'h0, s[p], o[p], d[p], r[p], u[p]};
  endfunction : pin_cfg_byte

  function automatic logic op_known(input logic [7:0] op);
    return op inside {hcpr_pkg::OP_PIN_CFG_WR, hcpr_pkg::OP_PIN_CFG_RD, hcpr_pkg::OP_PIN_LVL_WR,
                      hcpr_pkg::OP_PIN_LVL_RD, hcpr_pkg::OP_RAIL_WR, hcpr_pkg::OP_RAIL_RD,
                      hcpr_pkg::OP_ILIM_WR, hcpr_pkg::OP_ILIM_RD, hcpr_pkg::OP_THERM_WR};
  endfunction : op_known

  assign op_wr      = wr_i && (addr_i == hcpr_pkg::ADDR_OPCODE);
  assign chg_insert = charger_input_valid_i && !chg_prev;

  // Safe output skips the sequence check
  always_comb begin
    gate = rail_strict(rail_sequence_setting_i, rail_enable_source_i);
    gate[hcpr_pkg::RAIL_SAFE_OUT] =
      (rail_enable_source_i[2*hcpr_pkg::RAIL_SAFE_OUT +: 2] == hcpr_pkg::SRC_PIN_REGS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer: opcode write starts a one-cycle execution
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state  <= hcpr_pkg::ST_IDLE;
      cmd_op <= hcpr_pkg::BYTE_RST;
    end else begin
      case (state)
        hcpr_pkg::ST_IDLE: if (op_wr) begin
          state  <= hcpr_pkg::ST_EXEC;
          cmd_op <= wr_data_i;
        end
        hcpr_pkg::ST_EXEC: if (op_wr) begin
          cmd_op <= wr_data_i;
        end else begin
          state <= hcpr_pkg::ST_IDLE;
        end
        default: state <= hcpr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 7; i++) pay_out[i] <= hcpr_pkg::BYTE_RST;
      direct_level <= hcpr_pkg::PIN_VEC_RST;
    end else if (wr_i) begin
      if (addr_i >= hcpr_pkg::ADDR_PAY_OUT0 && addr_i <= hcpr_pkg::ADDR_PAY_OUTN) begin
        pay_out[3'(addr_i - hcpr_pkg::ADDR_PAY_OUT0)] <= wr_data_i;
      end
      if (addr_i == hcpr_pkg::ADDR_DIRECT) begin
        direct_level <= wr_data_i[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin settings and levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {dir_vec, od_vec, src_vec, res_vec, pup_vec} <= {5{hcpr_pkg::PIN_VEC_RST}};
      pin_level <= hcpr_pkg::PIN_VEC_RST;
    end else if (state == hcpr_pkg::ST_EXEC) begin
      if (cmd_op == hcpr_pkg::OP_PIN_CFG_WR) begin
        for (int p = 0; p < hcpr_pkg::NUM_PINS; p++) begin
          src_vec[p] <= pay_out[p][hcpr_pkg::PCFG_SRC];
          od_vec[p]  <= pay_out[p][hcpr_pkg::PCFG_OD];
          dir_vec[p] <= pay_out[p][hcpr_pkg::PCFG_DIR];
          res_vec[p] <= pay_out[p][hcpr_pkg::PCFG_RES];
          pup_vec[p] <= pay_out[p][hcpr_pkg::PCFG_PUP];
        end
      end
      if (cmd_op == hcpr_pkg::OP_PIN_LVL_WR) begin
        pin_level <= pay_out[0][4:0];
      end
    end
  end

  // Rail pin enables: defaults need the strap inputs, so load after reset release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < 5; p++) pin_en[p] <= hcpr_pkg::BYTE_RST;
      boot_loaded <= 1'b0;
    end else if (!boot_loaded) begin
      boot_loaded <= 1'b1;
      for (int p = 0; p < 5; p++) pin_en[p] <= rail_strict(rail_sequence_setting_i, rail_enable_source_i);
    end else if (state == hcpr_pkg::ST_EXEC && cmd_op == hcpr_pkg::OP_RAIL_WR) begin
      for (int p = 0; p < 5; p++) pin_en[p] <= pay_out[p];
    end
  end

  // Charger settings; insertion beats a same-cycle write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chg_prev               <= 1'b0;
      input_limit_select_o   <= hcpr_pkg::ILIM_SEL_RST;
      input_limit_blanking_o <= hcpr_pkg::ILIM_BLANK_RST;
      thermal_retry_timer_o  <= hcpr_pkg::THERM_RST;
    end else begin
      chg_prev <= charger_input_valid_i;
      if (chg_insert) begin
        input_limit_select_o   <= hcpr_pkg::ILIM_SEL_RST;
        input_limit_blanking_o <= hcpr_pkg::ILIM_BLANK_RST;
      end else if (state == hcpr_pkg::ST_EXEC && cmd_op == hcpr_pkg::OP_ILIM_WR) begin
        input_limit_select_o   <= pay_out[0][2:0];
        input_limit_blanking_o <= pay_out[0][hcpr_pkg::ILIM_BLANK_LSB +: 2];
      end
      if (state == hcpr_pkg::ST_EXEC && cmd_op == hcpr_pkg::OP_THERM_WR) begin
        thermal_retry_timer_o <= pay_out[0][1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response mailbox; zero opcode byte means not yet done
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_op <= hcpr_pkg::BYTE_RST;
      for (int i = 0; i < 5; i++) resp_pay[i] <= hcpr_pkg::BYTE_RST;
    end else if (op_wr) begin
      resp_op <= hcpr_pkg::BYTE_RST;
    end else if (state == hcpr_pkg::ST_EXEC) begin
      resp_op <= op_known(cmd_op) ? cmd_op : hcpr_pkg::OP_UNKNOWN_RSP;
      case (cmd_op)
        hcpr_pkg::OP_PIN_CFG_RD: for (int p = 0; p < 5; p++) begin
          resp_pay[p] <= pin_cfg_byte(3'(p), src_vec, od_vec, dir_vec, res_vec, pup_vec);
        end
        hcpr_pkg::OP_PIN_LVL_RD: begin
          resp_pay[0] <= {3'h0, pin_level};
          resp_pay[1] <= {3'h0, multipurpose_pin_i};
        end
        hcpr_pkg::OP_RAIL_RD: for (int p = 0; p < 5; p++) resp_pay[p] <= pin_en[p];
        hcpr_pkg::OP_ILIM_RD: resp_pay[0] <= {3'h0, input_limit_blanking_o, input_limit_select_o};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= hcpr_pkg::BYTE_RST;
    end else if (rd_i) begin
      if (addr_i == hcpr_pkg::ADDR_RESP_OP) rd_data_o <= resp_op;
      else if (addr_i >= hcpr_pkg::ADDR_RESP_PAY && addr_i <= hcpr_pkg::ADDR_RESP_END)
        rd_data_o <= resp_pay[3'(addr_i - hcpr_pkg::ADDR_RESP_PAY)];
      else if (addr_i == hcpr_pkg::ADDR_STATUS)
        rd_data_o <= (state == hcpr_pkg::ST_EXEC) ? hcpr_pkg::STATUS_BUSY : hcpr_pkg::BYTE_RST;
      else if (addr_i == hcpr_pkg::ADDR_DIRECT) rd_data_o <= {3'h0, direct_level};
      else rd_data_o <= hcpr_pkg::BYTE_RST;
    end else begin
      rd_data_o <= hcpr_pkg::BYTE_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; open drain releases the pin for a high level
  always_comb begin
    for (int p = 0; p < hcpr_pkg::NUM_PINS; p++) begin
      next_out[p] = 1'b0;
      next_oe[p]  = 1'b0;
      if (dir_vec[p]) begin
        if (od_vec[p]) begin
          next_oe[p] = !(src_vec[p] ? direct_level[p] : pin_level[p]);
        end else begin
          next_out[p] = src_vec[p] ? direct_level[p] : pin_level[p];
          next_oe[p]  = 1'b1;
        end
      end
    end
  end

  always_comb begin
    next_rail = 8'h00;
    for (int p = 0; p < hcpr_pkg::NUM_PINS; p++) begin
      next_rail = next_rail | (pin_en[p] & {8{multipurpose_pin_i[p]}});
    end
    next_rail = next_rail & gate;
    next_rail[hcpr_pkg::RAIL_SAFE_OUT] = next_rail[hcpr_pkg::RAIL_SAFE_OUT] & charger_input_valid_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      multipurpose_pin_o    <= hcpr_pkg::PIN_VEC_RST;
      multipurpose_pin_oe_o <= hcpr_pkg::PIN_VEC_RST;
      pin_pull_up_o         <= hcpr_pkg::PIN_VEC_RST;
      pin_pull_down_o       <= hcpr_pkg::PIN_VEC_RST;
      rail_on_o             <= hcpr_pkg::BYTE_RST;
    end else begin
      multipurpose_pin_o    <= next_out;
      multipurpose_pin_oe_o <= next_oe;
      pin_pull_up_o         <= ~dir_vec & res_vec & pup_vec;
      pin_pull_down_o       <= ~dir_vec & res_vec & ~pup_vec;
      rail_on_o             <= next_rail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  input_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (multipurpose_pin_oe_o & ~$past(dir_vec)) == 5'h00) else $error("input pin driven");
  out_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((multipurpose_pin_o ^ ((($past(src_vec) & $past(direct_level)) | (~$past(src_vec) & $past(pin_level)))))
         & $past(dir_vec) & ~$past(od_vec)) == 5'h00) else $error("output level wrong source");
  open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (multipurpose_pin_o & $past(od_vec)) == 5'h00) else $error("open drain pin driven high");
  pull_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((pin_pull_up_o | pin_pull_down_o) & ~($past(res_vec) & ~$past(dir_vec))) == 5'h00)
    else $error("pull without resistor");
  pull_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (pin_pull_up_o & ~$past(pup_vec)) == 5'h00 && (pin_pull_down_o & $past(pup_vec)) == 5'h00)
    else $error("wrong pull direction");
  resp_echo_a: assert property (@(posedge clk_i) disable iff (rst_i)
    op_wr && op_known(wr_data_i) ##1 !op_wr |=> resp_op == $past(wr_data_i, 2)) else $error("response opcode wrong");
  charger_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chg_insert |=> input_limit_select_o == hcpr_pkg::ILIM_SEL_RST
                   && input_limit_blanking_o == hcpr_pkg::ILIM_BLANK_RST)
    else $error("charger defaults not restored");
  rail_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (rail_on_o & ~$past(gate)) == 8'h00) else $error("rail enabled without gate");
  safe_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rail_on_o[hcpr_pkg::RAIL_SAFE_OUT] |-> $past(charger_input_valid_i)) else $error("safe output without charger");
  ilim_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == hcpr_pkg::ST_EXEC && cmd_op == hcpr_pkg::OP_ILIM_WR && !chg_insert
    |=> input_limit_select_o == $past(pay_out[0][2:0])) else $error("input limit not written");

  cfg_read_c:  cover property (@(posedge clk_i) state == hcpr_pkg::ST_EXEC && cmd_op == hcpr_pkg::OP_PIN_CFG_RD);
  rail_on_c:   cover property (@(posedge clk_i) rail_on_o != 8'h00);
  insert_wr_c: cover property (@(posedge clk_i) chg_insert && state == hcpr_pkg::ST_EXEC);

endmodule : hcpr_top

`default_nettype wire

/* hw/hcpr_pkg.sv */
`default_nettype none

package hcpr_pkg;

  // Mailbox byte addresses on the register port
  localparam logic [7:0] ADDR_OPCODE   = 8'h00;
  localparam logic [7:0] ADDR_PAY_OUT0 = 8'h01;
  localparam logic [7:0] ADDR_PAY_OUTN = 8'h07;
  localparam logic [7:0] ADDR_RESP_OP  = 8'h08;
  localparam logic [7:0] ADDR_RESP_PAY = 8'h09;
  localparam logic [7:0] ADDR_RESP_END = 8'h0D;
  localparam logic [7:0] ADDR_STATUS   = 8'h0E;
  localparam logic [7:0] ADDR_DIRECT   = 8'h0F;

  // Command opcodes
  localparam logic [7:0] OP_PIN_CFG_WR  = 8'h01;
  localparam logic [7:0] OP_PIN_CFG_RD  = 8'h02;
  localparam logic [7:0] OP_PIN_LVL_WR  = 8'h03;
  localparam logic [7:0] OP_PIN_LVL_RD  = 8'h04;
  localparam logic [7:0] OP_RAIL_WR     = 8'h06;
  localparam logic [7:0] OP_RAIL_RD     = 8'h07;
  localparam logic [7:0] OP_ILIM_WR     = 8'h10;
  localparam logic [7:0] OP_ILIM_RD     = 8'h11;
  localparam logic [7:0] OP_THERM_WR    = 8'h12;
  localparam logic [7:0] OP_UNKNOWN_RSP = 8'hFF;

  // Pin configuration byte fields
  localparam int PCFG_SRC = 4;
  localparam int PCFG_OD  = 3;
  localparam int PCFG_DIR = 2;
  localparam int PCFG_RES = 1;
  localparam int PCFG_PUP = 0;

  // Rail bit positions in a pin-enable byte
  localparam int RAIL_SAFE_OUT = 6;
  localparam int NUM_PINS      = 5;
  localparam int NUM_RAILS     = 8;

  // Rail gating codes
  localparam logic [2:0] SEQ_PIN_CTRL = 3'h7;
  localparam logic [1:0] SRC_PIN_REGS = 2'h2;

  // Charger input limit byte fields and defaults
  localparam int          ILIM_BLANK_LSB = 3;
  localparam logic [2:0]  ILIM_SEL_RST   = 3'h0;
  localparam logic [1:0]  ILIM_BLANK_RST = 2'h0;
  localparam logic [1:0]  THERM_RST      = 2'h0;

  // Reset values
  localparam logic [4:0]  PIN_VEC_RST  = 5'h00;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [7:0]  STATUS_BUSY  = 8'h01;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } hcpr_state_t;

endpackage : hcpr_pkg

`default_nettype wire

/* tb/hcpr_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

module hcpr_pin_model #(
  parameter logic [4:0] BOARD_PULLUP = 5'h02
) (
  input  wire logic       clk_i,
  input  wire logic [4:0] pin_drive_i,
  input  wire logic [4:0] pin_oe_i,
  input  wire logic [4:0] pull_up_i,
  input  wire logic [4:0] pull_down_i,
  output logic      [4:0] pin_level_o
);
  // A floating pin must not settle to a convenient value
  logic toggle = 1'b0;

  always @(posedge clk_i) toggle <= ~toggle;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe_i[i]) pin_level_o[i] = pin_drive_i[i];
      else if (pull_up_i[i] || BOARD_PULLUP[i]) pin_level_o[i] = 1'b1;
      else if (pull_down_i[i]) pin_level_o[i] = 1'b0;
      else pin_level_o[i] = toggle;
    end
  end
endmodule : hcpr_pin_model

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       clk_i, rst_i, wr_i, rd_i, chg;
  logic [7:0] addr_i, wr_data_i, rd_data_o, rail_on, d;
  logic [4:0] pin_in, pin_out, pin_oe, pu, pd;
  logic [2:0] lim_sel;
  logic [1:0] lim_blank, therm;
  logic [7:0] p [5];
  int         bad_count, n_checks;

  hcpr_top hcpr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .multipurpose_pin_i(pin_in),
    .multipurpose_pin_o(pin_out), .multipurpose_pin_oe_o(pin_oe), .pin_pull_up_o(pu),
    .pin_pull_down_o(pd), .rail_sequence_setting_i(24'h000007), .rail_enable_source_i(16'h200A),
    .charger_input_valid_i(chg), .rail_on_o(rail_on), .input_limit_select_o(lim_sel),
    .input_limit_blanking_o(lim_blank), .thermal_retry_timer_o(therm));

  hcpr_pin_model hcpr_pin_model_inst (.clk_i(clk_i), .pin_drive_i(pin_out), .pin_oe_i(pin_oe),
    .pull_up_i(pu), .pull_down_i(pd), .pin_level_o(pin_in));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wr_data_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd

  // Payload first, opcode last; busy poll is bounded
  task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] rsp);
    int k;
    for (int i = 0; i < n; i++) wr(hcpr_pkg::ADDR_PAY_OUT0 + 8'(i), p[i]);
    wr(hcpr_pkg::ADDR_OPCODE, op);
    k = 0;
    do begin
      rd(hcpr_pkg::ADDR_STATUS);
      k++;
    end while (d[0] !== 1'b0 && k < 8);
    if (d[0] !== 1'b0) begin
      bad_count++;
      test_done();
    end
    rd(hcpr_pkg::ADDR_RESP_OP);
    chk("resp_op", rsp, d);
  endtask : cmd

  task automatic pay(input int i, input logic [7:0] exp);
    rd(hcpr_pkg::ADDR_RESP_PAY + 8'(i));
    chk("payload", exp, d);
  endtask : pay

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_rail_reset();
    cmd(hcpr_pkg::OP_RAIL_RD, 0, hcpr_pkg::OP_RAIL_RD);
    for (int i = 0; i < 5; i++) pay(i, 8'h01);
  endtask : t_rail_reset

  task automatic t_pins();
    logic [7:0] cfg [5];
    // Pin 1 carries a resistor bit while an output: it must stay unpulled
    cfg = '{8'h05, 8'h0E, 8'h03, 8'h02, 8'h14};
    wr(hcpr_pkg::ADDR_DIRECT, 8'h10);
    p = cfg;
    cmd(hcpr_pkg::OP_PIN_CFG_WR, 5, hcpr_pkg::OP_PIN_CFG_WR);
    p[0] = 8'hE3;
    cmd(hcpr_pkg::OP_PIN_LVL_WR, 1, hcpr_pkg::OP_PIN_LVL_WR);
    cmd(hcpr_pkg::OP_PIN_CFG_RD, 0, hcpr_pkg::OP_PIN_CFG_RD);
    for (int i = 0; i < 5; i++) pay(i, cfg[i]);
    chk("oe", 8'h11, {3'h0, pin_oe});
    chk("out", 8'h11, {3'h0, pin_out});
    chk("pull_up", 8'h04, {3'h0, pu});
    chk("pull_down", 8'h08, {3'h0, pd});
    cmd(hcpr_pkg::OP_PIN_LVL_RD, 0, hcpr_pkg::OP_PIN_LVL_RD);
    pay(0, 8'h03);
    pay(1, 8'h17);
    wr(hcpr_pkg::ADDR_DIRECT, 8'h00);
    repeat (3) @(posedge clk_i);
    #1 chk("direct_src", 8'h01, {3'h0, pin_out});
  endtask : t_pins

  task automatic t_ilim();
    for (int c = 0; c < 8; c++) begin
      p[0] = {3'h0, 2'(c), 3'(c)};
      cmd(hcpr_pkg::OP_ILIM_WR, 1, hcpr_pkg::OP_ILIM_WR);
      chk("limit", {5'h00, 3'(c)}, {5'h00, lim_sel});
      chk("blank", {6'h00, 2'(c)}, {6'h00, lim_blank});
    end
    cmd(hcpr_pkg::OP_ILIM_RD, 0, hcpr_pkg::OP_ILIM_RD);
    pay(0, 8'h1F);
    p[0] = 8'h02;
    cmd(hcpr_pkg::OP_THERM_WR, 1, hcpr_pkg::OP_THERM_WR);
    chk("thermal", 8'h02, {6'h00, therm});
    // No charger writes follow the insertion
    @(posedge clk_i);
    chg <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("limit_dflt", 8'h00, {3'h0, lim_blank, lim_sel});
    chk("thermal_kept", 8'h02, {6'h00, therm});
    cmd(hcpr_pkg::OP_ILIM_RD, 0, hcpr_pkg::OP_ILIM_RD);
    pay(0, 8'h00);
    cmd(8'h55, 0, hcpr_pkg::OP_UNKNOWN_RSP);
  endtask : t_ilim

  task automatic t_rails();
    p = '{8'h43, 8'h00, 8'h00, 8'h00, 8'h00};
    cmd(hcpr_pkg::OP_RAIL_WR, 5, hcpr_pkg::OP_RAIL_WR);
    chk("rail_on", 8'h41, rail_on);
    cmd(hcpr_pkg::OP_RAIL_RD, 0, hcpr_pkg::OP_RAIL_RD);
    for (int i = 0; i < 5; i++) pay(i, p[i]);
    @(posedge clk_i);
    chg <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("rail_nochg", 8'h01, rail_on);
    p[0] = 8'h00;
    cmd(hcpr_pkg::OP_PIN_LVL_WR, 1, hcpr_pkg::OP_PIN_LVL_WR);
    repeat (4) @(posedge clk_i);
    #1 chk("rail_pinlow", 8'h00, rail_on);
  endtask : t_rails

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; chg = 1'b0;
    addr_i = 8'h00; wr_data_i = 8'h00;
    bad_count = 0; n_checks = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_rail_reset();
    t_pins();
    t_ilim();
    t_rails();
    test_done();
  end
endmodule : testbench

`default_nettype wire
